// ==== core/bcr_regs_map.vh ====
// offsets, fields, reset values and timing of the board control bank
`ifndef BCR_REGS_MAP_VH
`define BCR_REGS_MAP_VH

// register offsets on the byte-wide register port
`define BCR_ADDR_RST_SWITCH 8'h0B
`define BCR_ADDR_MISC_ONE 8'h0C
`define BCR_ADDR_MISC_TWO 8'h0D
`define BCR_ADDR_FW_UNLOCK 8'h0E
`define BCR_ADDR_SCRATCH 8'h0F
`define BCR_ADDR_G2_CTRL 8'h10
`define BCR_ADDR_G2_DIV 8'h11
`define BCR_ADDR_G2_CMD0 8'h14
`define BCR_ADDR_G2_CMD1 8'h15
`define BCR_ADDR_G2_CMD2 8'h16
`define BCR_ADDR_G2_CMD3 8'h17
`define BCR_ADDR_G2_RB0 8'h18
`define BCR_ADDR_G2_RB1 8'h19
`define BCR_ADDR_G2_RB2 8'h1A
`define BCR_ADDR_G2_RB3 8'h1B
`define BCR_ADDR_G3_CTRL 8'h20

// reset values
`define BCR_MISC_ONE_RST 8'h1C
`define BCR_DIV_RST 8'h03
`define BCR_ZERO_RST 8'h00

// unlock key of the firmware-update pass-through
`define BCR_FW_KEY 8'h68

// reset/switch status bit positions
`define BCR_RS_TRIG_BIT 5
`define BCR_RS_SELSW_BIT 6
`define BCR_RS_USRSW_BIT 7

// misc one bit positions; bits 1-0 are plain storage, bit 7 reads zero
`define BCR_M1_RSV_MSB 1
`define BCR_M1_NAND_WP_BIT 2
`define BCR_M1_EMU_EN_BIT 3
`define BCR_M1_NOR_WP_BIT 4
`define BCR_M1_EE_WP_BIT 5
`define BCR_M1_LVL_EN_BIT 6

// misc two bit positions
`define BCR_M2_FW_EN_BIT 0
`define BCR_M2_HOUT_BIT 1
`define BCR_M2_SYSCLK_BIT 2

// generator control bits; 4-2 enable por, full, warm pulses
`define BCR_GC_START_BIT 0
`define BCR_GC_BUSY_BIT 1
`define BCR_GC_PEN_LSB 2
`define BCR_GC_PEN_MSB 4

// link clock: add source MHz per mclk, wrap at (div+1)*mclk MHz
`define BCR_SRC_MHZ 16'h0030
`define BCR_MCLK_MHZ 16'h0019
`define BCR_FRAME_LAST 6'h1F

// reset pulse width
`define BCR_MCLK_PERIOD_NS 40
`define BCR_PULSE_NS 1000
`define BCR_PULSE_CYC ((`BCR_PULSE_NS + `BCR_MCLK_PERIOD_NS - 1) / `BCR_MCLK_PERIOD_NS)

`endif

// ==== core/bcr_board_ctrl.v ====
// board control register bank with firmware pass-through and clock generator command engines
//
// Summary of operation
// [R1] status bits 5-7 show trigger, select, user switch
// [R2] misc one resets to 1Ch, host writable
// [R3] misc one bit 2 drives raw flash protect
// [R4] misc one bit 3 enables emulator card
// [R5] misc one bit 4 drives serial flash protect
// [R6] misc one bit 5 drives config memory protect
// [R7] bit 6 level shifter enable; bit 7 reserved
// [R8] misc two bit 0 shows pass-through enabled
// [R9] writing 68h unlocks pass-through, else locks
// [R10] gpio 12-15 routed to update port when unlocked
// [R11] misc two bits 1-2 show host levels
// [R12] scratch byte, read back, resets zero
// [R13] write start bit to send command; reads 0 idle
// [R14] busy bit high while frame in progress
// [R15] bits 2-4 request reset pulses after frame
// [R16] link clock 48MHz over (X+1)*2, reset 03h
// [R17] divider zero equals divider one
// [R18] byte 0 holds address and data 3:0
// [R19] bytes 1-3 hold data 27:4
// [R20] readback byte 0 holds address, data 3:0
// [R21] readback bytes 1-3 hold data 27:4
// [R22] generator three engine started at 20h bit 0
// [R23] 32-bit frame, byte 0 first, select held
// [R24] busy, start clear after frame and pulses
// [R25] read-only writes ignored, reserved reads zero
`timescale 1ns/1ns
`include "bcr_regs_map.vh"

module bcr_board_ctrl (
    // clock and reset
    input wire mclk_in,
    input wire srst_in,
    // register port
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    // switch and host status levels
    input wire trigger_reset_level_in,
    input wire serial_link_select_switch_in,
    input wire user_switch_in,
    input wire host_out_level_in,
    input wire host_system_clock_out_level_in,
    // board memory and card controls
    output wire nand_wp_n_out,
    output wire nor_wp_n_out,
    output wire eeprom_wp_out,
    output wire emulator_card_enable_out,
    output wire level_shifter_enable_out,
    // host gpio 12-15 and firmware-update port
    input wire host_gpio12_in,
    input wire host_gpio13_in,
    input wire host_gpio14_in,
    output wire host_gpio15_out,
    output wire host_gpio15_oe_out,
    output wire fw_update_sclk_out,
    output wire fw_update_select_n_out,
    output wire fw_update_mosi_out,
    input wire fw_update_miso_in,
    // clock generator links, bit 0 generator two, bit 1 generator three
    output wire [1:0] clkgen_sclk_out,
    output wire [1:0] clkgen_select_n_out,
    output wire [1:0] clkgen_mosi_out,
    input wire [1:0] clkgen_miso_in,
    // host reset outputs, active low
    output wire host_power_on_reset_n_out,
    output wire host_full_reset_n_out,
    output wire host_warm_reset_n_out
);

    // engine states
    localparam ST_IDLE = 2'b00;
    localparam ST_SHIFT = 2'b01;
    localparam ST_PULSE = 2'b10;
    localparam ST_DONE = 2'b11;

    // software registers
    reg [7:0] misc_one_q; // board controls
    reg [7:0] fw_unlock_q; // pass-through key
    reg [7:0] scratch_q; // free storage
    reg [2:0] g2_pulse_en_q; // por, full, warm enables
    reg [7:0] g2_div_q; // link clock divider
    reg [31:0] g2_cmd_q; // command bytes 3..0
    reg [1:0] run_q; // start bit per engine, doubles as busy

    // per-engine flat buses
    wire [15:0] eng_div; // divider per engine
    wire [63:0] eng_cmd; // command per engine
    wire [5:0] eng_pen; // pulse enables per engine
    wire [1:0] eng_done; // one-cycle finish per engine
    wire [5:0] eng_pulse; // active-high pulse requests
    wire [63:0] eng_rb; // captured response per engine
    wire fw_en; // pass-through unlocked

    ////////////////////////////////////////////////////////////////////////
    // firmware-update pass-through

    // [R9] key compare
    assign fw_en = (fw_unlock_q == `BCR_FW_KEY);

    // [R10] gpio routing, combinational for host spi timing
    assign fw_update_sclk_out = fw_en ? host_gpio12_in : 1'b0;
    assign fw_update_select_n_out = fw_en ? host_gpio13_in : 1'b1;
    assign fw_update_mosi_out = fw_en ? host_gpio14_in : 1'b0;
    assign host_gpio15_out = fw_en ? fw_update_miso_in : 1'b0;
    // gpio 15 released when locked, free for host use
    assign host_gpio15_oe_out = fw_en;

    ////////////////////////////////////////////////////////////////////////
    // board control pins

    // [R3] raw flash protect
    assign nand_wp_n_out = misc_one_q[`BCR_M1_NAND_WP_BIT];
    // [R4] emulator card enable
    assign emulator_card_enable_out = misc_one_q[`BCR_M1_EMU_EN_BIT];
    // [R5] serial flash protect
    assign nor_wp_n_out = misc_one_q[`BCR_M1_NOR_WP_BIT];
    // [R6] config memory protect
    assign eeprom_wp_out = misc_one_q[`BCR_M1_EE_WP_BIT];
    // [R7] level shifter enable
    assign level_shifter_enable_out = misc_one_q[`BCR_M1_LVL_EN_BIT];

    // [R15] pulses from either engine, low while requested
    assign host_power_on_reset_n_out = ~(eng_pulse[0] | eng_pulse[3]);
    assign host_full_reset_n_out = ~(eng_pulse[1] | eng_pulse[4]);
    assign host_warm_reset_n_out = ~(eng_pulse[2] | eng_pulse[5]);

    // generator three: start bit only, default divider,
    // zero command, no reset pulses
    assign eng_div = {`BCR_DIV_RST, g2_div_q};
    assign eng_cmd = {32'h0000_0000, g2_cmd_q};
    assign eng_pen = {3'b000, g2_pulse_en_q};

    ////////////////////////////////////////////////////////////////////////
    // register writes

    always @(posedge mclk_in) begin
        if (srst_in) begin
            // [R2] misc one reset value
            misc_one_q <= `BCR_MISC_ONE_RST;
            fw_unlock_q <= `BCR_ZERO_RST;
            // [R12] scratch resets zero
            scratch_q <= `BCR_ZERO_RST;
            g2_pulse_en_q <= 3'b000;
            // [R16] divider reset value
            g2_div_q <= `BCR_DIV_RST;
            g2_cmd_q <= 32'h0000_0000;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                // [R7] bit 7 reserved, write ignored
                `BCR_ADDR_MISC_ONE: misc_one_q <= {1'b0, reg_wdata_in[`BCR_M1_LVL_EN_BIT:0]};

                `BCR_ADDR_FW_UNLOCK: fw_unlock_q <= reg_wdata_in;
                `BCR_ADDR_SCRATCH: scratch_q <= reg_wdata_in;

                // [R15] pulse enables stored
                `BCR_ADDR_G2_CTRL: g2_pulse_en_q <= reg_wdata_in[`BCR_GC_PEN_MSB:`BCR_GC_PEN_LSB];
                `BCR_ADDR_G2_DIV: g2_div_q <= reg_wdata_in;

                // [R18] byte 0: address nibble low, data 3:0 high
                `BCR_ADDR_G2_CMD0: g2_cmd_q[7:0] <= reg_wdata_in;
                // [R19] data 27:4 in bytes 1-3
                `BCR_ADDR_G2_CMD1: g2_cmd_q[15:8] <= reg_wdata_in;
                `BCR_ADDR_G2_CMD2: g2_cmd_q[23:16] <= reg_wdata_in;
                `BCR_ADDR_G2_CMD3: g2_cmd_q[31:24] <= reg_wdata_in;

                // [R25] read-only and reserved offsets ignore writes
                default: misc_one_q <= misc_one_q;
            endcase
        end
    end

    // start bits: set by writing 1, cleared at engine finish
    always @(posedge mclk_in) begin
        if (srst_in) begin
            run_q <= 2'b00;
        end else begin
            // [R24] clear only when the engine reports completion
            run_q <= run_q & ~eng_done;
            // [R13] start generator two; ignored while already running
            if (reg_wr_in && reg_addr_in == `BCR_ADDR_G2_CTRL && reg_wdata_in[`BCR_GC_START_BIT] && !run_q[0]) begin
                run_q[0] <= 1'b1;
            end
            // [R22] start generator three
            if (reg_wr_in && reg_addr_in == `BCR_ADDR_G3_CTRL && reg_wdata_in[`BCR_GC_START_BIT] && !run_q[1]) begin
                run_q[1] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register reads, one cycle after the read strobe

    always @(posedge mclk_in) begin
        if (srst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                // [R1] live switch levels, other bits zero
                `BCR_ADDR_RST_SWITCH: begin
                    reg_rdata_out <= {user_switch_in, serial_link_select_switch_in, trigger_reset_level_in, 5'h00};
                end
                `BCR_ADDR_MISC_ONE: reg_rdata_out <= misc_one_q;
                // [R8] [R11] pass-through state and host levels
                `BCR_ADDR_MISC_TWO: begin
                    reg_rdata_out <= {5'h00, host_system_clock_out_level_in, host_out_level_in, fw_en};
                end
                `BCR_ADDR_FW_UNLOCK: reg_rdata_out <= fw_unlock_q;
                `BCR_ADDR_SCRATCH: reg_rdata_out <= scratch_q;

                // [R14] busy bit mirrors the running engine
                `BCR_ADDR_G2_CTRL: reg_rdata_out <= {3'b000, g2_pulse_en_q, run_q[0], run_q[0]};
                `BCR_ADDR_G2_DIV: reg_rdata_out <= g2_div_q;

                `BCR_ADDR_G2_CMD0: reg_rdata_out <= g2_cmd_q[7:0];
                `BCR_ADDR_G2_CMD1: reg_rdata_out <= g2_cmd_q[15:8];
                `BCR_ADDR_G2_CMD2: reg_rdata_out <= g2_cmd_q[23:16];
                `BCR_ADDR_G2_CMD3: reg_rdata_out <= g2_cmd_q[31:24];

                // [R20] readback byte 0: address and data 3:0
                `BCR_ADDR_G2_RB0: reg_rdata_out <= eng_rb[7:0];
                // [R21] readback data 27:4
                `BCR_ADDR_G2_RB1: reg_rdata_out <= eng_rb[15:8];
                `BCR_ADDR_G2_RB2: reg_rdata_out <= eng_rb[23:16];
                `BCR_ADDR_G2_RB3: reg_rdata_out <= eng_rb[31:24];

                `BCR_ADDR_G3_CTRL: reg_rdata_out <= {6'h00, run_q[1], run_q[1]};
                // [R25] reserved offsets read zero
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command engines, one per clock generator

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_eng
            reg [1:0] st_q; // engine state
            reg [15:0] acc_q; // link clock phase accumulator
            reg [31:0] sh_q; // outgoing frame
            reg [31:0] rb_q; // incoming response
            reg [5:0] cnt_q; // bits sent
            reg [1:0] pidx_q; // pulse slot 0 por, 1 full, 2 warm
            reg [7:0] pcnt_q; // pulse width counter
            reg [2:0] pulse_q; // active pulse per slot
            reg sclk_q;
            reg sel_n_q;
            wire [7:0] div_raw;
            wire [15:0] div_eff;
            wire [15:0] half_wrap;
            wire [15:0] acc_nx;
            wire tick;

            assign div_raw = eng_div[8 * ch +: 8];
            // [R17] zero behaves as one
            assign div_eff = (div_raw == 8'h00) ? 16'h0001 : {8'h00, div_raw};
            // [R16] half period is (X+1) source ticks; jitter is one mclk
            assign half_wrap = (div_eff + 16'h0001) * `BCR_MCLK_MHZ;
            assign acc_nx = acc_q + `BCR_SRC_MHZ;
            assign tick = (acc_nx >= half_wrap);

            // frame shifting, reset pulses and completion
            always @(posedge mclk_in) begin
                if (srst_in) begin
                    st_q <= ST_IDLE;
                    acc_q <= 16'h0000;
                    sh_q <= 32'h0000_0000;
                    rb_q <= 32'h0000_0000;
                    cnt_q <= 6'h00;
                    pidx_q <= 2'b00;
                    pcnt_q <= 8'h00;
                    pulse_q <= 3'b000;
                    sclk_q <= 1'b0;
                    sel_n_q <= 1'b1;
                end else begin
                    case (st_q)
                        ST_IDLE: begin
                            if (run_q[ch]) begin
                                // [R23] load whole frame, select held low
                                sh_q <= eng_cmd[32 * ch +: 32];
                                sel_n_q <= 1'b0;
                                acc_q <= 16'h0000;
                                cnt_q <= 6'h00;
                                st_q <= ST_SHIFT;
                            end
                        end
                        ST_SHIFT: begin
                            acc_q <= tick ? (acc_nx - half_wrap) : acc_nx;
                            if (tick) begin
                                sclk_q <= ~sclk_q;
                                if (!sclk_q) begin
                                    // rising edge: capture response, lsb first
                                    rb_q <= {clkgen_miso_in[ch], rb_q[31:1]};
                                end else begin
                                    // [R23] falling edge: next bit, byte 0 first
                                    sh_q <= {1'b0, sh_q[31:1]};
                                    cnt_q <= cnt_q + 6'h01;
                                    if (cnt_q == `BCR_FRAME_LAST) begin
                                        sel_n_q <= 1'b1;
                                        pidx_q <= 2'b00;
                                        pcnt_q <= 8'h00;
                                        st_q <= ST_PULSE;
                                    end
                                end
                            end
                        end
                        ST_PULSE: begin
                            // [R15] one pulse per enabled slot, in order
                            if (eng_pen[3 * ch + pidx_q] && pcnt_q != `BCR_PULSE_CYC) begin
                                pulse_q[pidx_q] <= 1'b1;
                                pcnt_q <= pcnt_q + 8'h01;
                            end else begin
                                pulse_q <= 3'b000;
                                pcnt_q <= 8'h00;
                                pidx_q <= pidx_q + 2'b01;
                                if (pidx_q == 2'b10) begin
                                    st_q <= ST_DONE;
                                end
                            end
                        end
                        default: begin
                            // [R24] finish one cycle, then idle
                            st_q <= ST_IDLE;
                        end
                    endcase
                end
            end

            assign eng_done[ch] = (st_q == ST_DONE);
            assign eng_pulse[3 * ch +: 3] = pulse_q;
            assign eng_rb[32 * ch +: 32] = rb_q;
            assign clkgen_sclk_out[ch] = sclk_q;
            assign clkgen_select_n_out[ch] = sel_n_q;
            assign clkgen_mosi_out[ch] = sh_q[0];
        end
    endgenerate

endmodule

// ==== tb/bcr_board_ctrl_monitor.sv ====
// checker for the board control register bank
`timescale 1ns/1ns
module bcr_board_ctrl_monitor (
    // clock, reset and register port
    input wire mclk_in,
    input wire srst_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_rdata_out,
    // levels and board pins
    input wire trigger_reset_level_in,
    input wire serial_link_select_switch_in,
    input wire user_switch_in,
    input wire host_out_level_in,
    input wire host_system_clock_out_level_in,
    input wire nand_wp_n_out,
    input wire nor_wp_n_out,
    input wire eeprom_wp_out,
    input wire emulator_card_enable_out,
    input wire level_shifter_enable_out,
    input wire host_gpio12_in,
    input wire host_gpio13_in,
    input wire host_gpio14_in,
    input wire host_gpio15_out,
    input wire host_gpio15_oe_out,
    input wire fw_update_sclk_out,
    input wire fw_update_select_n_out,
    input wire fw_update_mosi_out,
    input wire fw_update_miso_in,
    // generator link and host resets
    input wire [1:0] clkgen_sclk_out,
    input wire [1:0] clkgen_select_n_out,
    input wire host_power_on_reset_n_out,
    input wire host_full_reset_n_out,
    input wire host_warm_reset_n_out
);
default clocking dc @(posedge mclk_in); endclocking
default disable iff (srst_in);
////////////////////////////////////////////////////////////
// all host resets released; pulse cycles and frame clocks counted
wire all_hi = host_power_on_reset_n_out & host_full_reset_n_out & host_warm_reset_n_out;
logic [5:0] low_q;
logic [6:0] bits_q;
logic sclk_q;
always @(posedge mclk_in) begin
    sclk_q <= clkgen_sclk_out[0];
    low_q <= (srst_in || all_hi) ? 6'h00 : low_q + 6'h01;
    if (srst_in || $fell(clkgen_select_n_out[0])) begin
        bits_q <= 7'h00;
    end else if (clkgen_sclk_out[0] && !sclk_q) begin
        bits_q <= bits_q + 7'h01;
    end
end
// start write while link and resets idle, then select held
sequence s_start;
    reg_wr_in && reg_addr_in == 8'h10 && reg_wdata_in[0] && clkgen_select_n_out[0] && all_hi;
endsequence
sequence s_open;
    ##2 !clkgen_select_n_out[0] [*2];
endsequence
////////////////////////////////////////////////////////////
AST_STATUS: assert property (reg_rd_in && reg_addr_in == 8'h0B |=> reg_rdata_out ==
    {$past(user_switch_in), $past(serial_link_select_switch_in), $past(trigger_reset_level_in), 5'h00})
    else $error("status byte wrong");
AST_MISC_PINS: assert property (reg_wr_in && reg_addr_in == 8'h0C |=> {level_shifter_enable_out,
    eeprom_wp_out, nor_wp_n_out, emulator_card_enable_out, nand_wp_n_out} == $past(reg_wdata_in[6:2]))
    else $error("misc pins wrong");
AST_UNLOCK: assert property (reg_wr_in && reg_addr_in == 8'h0E |=>
    host_gpio15_oe_out == ($past(reg_wdata_in) == 8'h68)) else $error("unlock wrong");
AST_ROUTE: assert property (host_gpio15_oe_out |-> fw_update_sclk_out == host_gpio12_in &&
    fw_update_select_n_out == host_gpio13_in && fw_update_mosi_out == host_gpio14_in &&
    host_gpio15_out == fw_update_miso_in) else $error("route wrong");
AST_MISC_TWO: assert property (reg_rd_in && reg_addr_in == 8'h0D |=> reg_rdata_out == {5'h00,
    $past(host_system_clock_out_level_in), $past(host_out_level_in), $past(host_gpio15_oe_out)})
    else $error("misc two wrong");
AST_FRAME_BITS: assert property ($rose(clkgen_select_n_out[0]) |-> bits_q == 7'h20)
    else $error("frame not 32 clocks");
AST_PULSE_WIDTH: assert property ($rose(all_hi) |-> low_q == 6'h19)
    else $error("pulse width wrong");
AST_BUSY: assert property (reg_rd_in && reg_addr_in == 8'h10 && (!clkgen_select_n_out[0] || !all_hi)
    |=> reg_rdata_out[1:0] == 2'h3) else $error("busy not shown");
AST_START: assert property (s_start |-> s_open) else $error("frame did not open");
endmodule
bind bcr_board_ctrl bcr_board_ctrl_monitor i_mon (.*);

// ==== tb/bcr_clkgen_model.sv ====
// behavioural clock generator on one command link
`timescale 1ns/1ns
module bcr_clkgen_model (
    // link pins
    input wire sclk_in,
    input wire select_n_in,
    input wire mosi_in,
    output logic miso_out,
    // response to send, command received
    input wire [31:0] resp_in,
    output logic [31:0] rx_out,
    output int frames_out
);
logic [31:0] tx_q;
logic open_q = 1'b0; // guards the unknown-to-high step at reset
initial begin
    miso_out = 1'b0;
    rx_out = 32'h00000000;
    frames_out = 0;
end
// first response bit ready at frame open
always @(negedge select_n_in) begin
    open_q = 1'b1;
    tx_q = resp_in;
    miso_out = resp_in[0];
end
// command taken lsb first on rising link clock
always @(posedge sclk_in) begin
    if (!select_n_in) begin
        rx_out = {mosi_in, rx_out[31:1]};
    end
end
// next response bit after each falling clock
always @(negedge sclk_in) begin
    if (!select_n_in) begin
        tx_q = tx_q >> 1;
        miso_out = tx_q[0];
    end
end
// released line shows the inverse of its last level
always @(posedge select_n_in) begin
    if (open_q) begin
        frames_out = frames_out + 1;
        miso_out = ~miso_out;
    end
end
endmodule

// ==== tb/bcr_board_ctrl_tb.sv ====
// self-checking bench for the board control register bank
`timescale 1ns/1ns
module bcr_board_ctrl_tb;
logic mclk_in = 1'b0;
logic srst_in = 1'b1;
logic [7:0] reg_addr_in = 8'h00;
logic [7:0] reg_wdata_in = 8'h00;
logic reg_wr_in = 1'b0;
logic reg_rd_in = 1'b0;
logic [4:0] lvl_q = 5'h00; // usr sel trig in 2:0, host levels in 4:3
logic [3:0] gp_q = 4'h0; // host gpio 12-14 and flash miso
logic [31:0] resp_q = 32'h00000000;
wire [7:0] reg_rdata_out;
wire [4:0] pins_w; // misc one bits 6:2
wire [4:0] fw_w; // oe, gpio15, mosi, select, clock
wire [1:0] ck_sclk;
wire [1:0] ck_sel;
wire [1:0] ck_mosi;
wire [1:0] ck_miso;
wire [2:0] rst_n_w; // warm, full, por
wire [31:0] rx0;
wire [31:0] rx1;
int frames0;
int frames1;
int bad_count = 0;
int cmp_count = 0;
int cyc = 0;
int lowcyc = 0;
int pc [3] = '{0, 0, 0};
logic [7:0] m [0:63]; // expected register contents
logic [7:0] adr_q [$] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h14, 8'h15,
    8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1F, 8'h20};
logic [7:0] keys [4] = '{8'h68, 8'h69, 8'h68, 8'h00};
logic [2:0] mk [4] = '{3'h7, 3'h0, 3'h5, 3'h2};
logic [31:0] cmd;
logic [7:0] v;
int e;
bcr_board_ctrl i_dut (.mclk_in(mclk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .trigger_reset_level_in(lvl_q[0]), .serial_link_select_switch_in(lvl_q[1]), .user_switch_in(lvl_q[2]),
    .host_out_level_in(lvl_q[3]), .host_system_clock_out_level_in(lvl_q[4]),
    .nand_wp_n_out(pins_w[0]), .emulator_card_enable_out(pins_w[1]), .nor_wp_n_out(pins_w[2]),
    .eeprom_wp_out(pins_w[3]), .level_shifter_enable_out(pins_w[4]),
    .host_gpio12_in(gp_q[0]), .host_gpio13_in(gp_q[1]), .host_gpio14_in(gp_q[2]),
    .host_gpio15_out(fw_w[3]), .host_gpio15_oe_out(fw_w[4]), .fw_update_sclk_out(fw_w[0]),
    .fw_update_select_n_out(fw_w[1]), .fw_update_mosi_out(fw_w[2]), .fw_update_miso_in(gp_q[3]),
    .clkgen_sclk_out(ck_sclk), .clkgen_select_n_out(ck_sel), .clkgen_mosi_out(ck_mosi),
    .clkgen_miso_in(ck_miso), .host_power_on_reset_n_out(rst_n_w[0]),
    .host_full_reset_n_out(rst_n_w[1]), .host_warm_reset_n_out(rst_n_w[2]));
bcr_clkgen_model i_gen2 (.sclk_in(ck_sclk[0]), .select_n_in(ck_sel[0]), .mosi_in(ck_mosi[0]),
    .miso_out(ck_miso[0]), .resp_in(resp_q), .rx_out(rx0), .frames_out(frames0));
bcr_clkgen_model i_gen3 (.sclk_in(ck_sclk[1]), .select_n_in(ck_sel[1]), .mosi_in(ck_mosi[1]),
    .miso_out(ck_miso[1]), .resp_in(resp_q), .rx_out(rx1), .frames_out(frames1));
////////////////////////////////////////////////////////////
initial begin
    forever #20 mclk_in = ~mclk_in;
end
// frame length, pulse cycles and hang limit
always @(posedge mclk_in) begin
    cyc++;
    if (ck_sel[0] === 1'b0) lowcyc++;
    for (int i = 0; i < 3; i++) if (rst_n_w[i] === 1'b0) pc[i]++;
    if (cyc == 20000) begin
        bad_count++;
        end_of_test();
    end
end
task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
        bad_count++;
        $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
    end
endtask
task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
        bad_count++;
        $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
endtask
// model update, then one write strobe
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    case (a)
        8'h0C: m[a[5:0]] = d & 8'h7F;
        8'h10: m[a[5:0]] = d & 8'h1C;
        8'h0E, 8'h0F, 8'h11, 8'h14, 8'h15, 8'h16, 8'h17: m[a[5:0]] = d;
        default: ;
    endcase
    @(posedge mclk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
endtask
task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
endtask
task automatic rdc(input logic [7:0] a);
    logic [7:0] d;
    rd(a, d);
    case (a)
        8'h0B: cmp8(d, {lvl_q[2:0], 5'h00});
        8'h0D: cmp8(d, {5'h00, lvl_q[4:3], m[6'h0E] == 8'h68});
        default: cmp8(d, m[a[5:0]]);
    endcase
endtask
task automatic poll(input logic [7:0] a, output logic [7:0] d);
    int n = 0;
    rd(a, d);
    while (d[1] === 1'b1 && n < 400) begin
        rd(a, d);
        n++;
    end
endtask
task automatic end_of_test;
    $display("compared %0d, unexpected %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
        $display("ALL CHECKS OK");
    end else begin
        $display("CHECKS NOT OK");
    end
    $finish;
endtask
////////////////////////////////////////////////////////////
initial begin
    foreach (m[i]) m[i] = 8'h00;
    m[6'h0C] = 8'h1C;
    m[6'h11] = 8'h03;
    void'($urandom(74301));
    repeat (20) @(posedge mclk_in);
    srst_in <= 1'b0;
    foreach (adr_q[i]) rdc(adr_q[i]);
    cmp8({3'h0, pins_w}, 8'h07);
    $display("test reset values done");
    // random writes everywhere, start bits kept clear
    repeat (3) begin
        lvl_q <= 5'($urandom);
        foreach (adr_q[i]) wr(adr_q[i], 8'($urandom) & (adr_q[i][3:0] == 4'h0 ? 8'hFE : 8'hFF));
        foreach (adr_q[i]) rdc(adr_q[i]);
        cmp8({3'h0, pins_w}, {3'h0, m[6'h0C][6:2]});
    end
    $display("test register access done");
    // pass-through keyed and closed
    foreach (keys[k]) begin
        wr(8'h0E, keys[k]);
        gp_q <= 4'($urandom);
        @(posedge mclk_in);
        #1 cmp8({3'h0, fw_w}, keys[k] == 8'h68 ? {4'h1, gp_q} : 8'h02);
        rdc(8'h0D);
    end
    $display("test update port done");
    // generator two frames over four dividers
    for (int f = 0; f < 4; f++) begin
        wr(8'h11, 8'(f));
        cmd = $urandom;
        resp_q <= $urandom;
        for (int j = 0; j < 4; j++) wr({6'h05, 2'(j)}, cmd[8 * j +: 8]);
        lowcyc = 0;
        pc = '{0, 0, 0};
        wr(8'h10, {3'h0, mk[f], 2'h1});
        rd(8'h10, v);
        cmp8({6'h00, v[1:0]}, 8'h03);
        if (f == 1) begin
            repeat (10) @(posedge mclk_in);
            wr(8'h10, 8'h01);
        end
        poll(8'h10, v);
        cmp8(v, {3'h0, mk[f], 2'h0});
        cmp32(rx0, cmd);
        cmp32(frames0, f + 1);
        e = ((f == 0 ? 1 : f) + 1) * 100 / 3;
        cmp32(lowcyc > e - 5 && lowcyc < e + 5, 1);
        for (int i = 0; i < 3; i++) cmp32(pc[i], mk[f][i] ? 25 : 0);
        for (int j = 0; j < 4; j++) m[{4'h6, 2'(j)}] = resp_q[8 * j +: 8];
        for (int j = 0; j < 4; j++) rdc({6'h06, 2'(j)});
    end
    $display("test generator two done");
    wr(8'h20, 8'h01);
    rd(8'h20, v);
    cmp8(v, 8'h03);
    poll(8'h20, v);
    cmp8(v, 8'h00);
    cmp32(rx1, 0);
    cmp32(frames1, 1);
    $display("test generator three done");
    end_of_test();
end
endmodule
